/* rtl/tef_top.sv */
/*
  Control slice of the converter: error and interrupt flags, test-input
  multiplexing, extra processing delay, coarse range counter, measurement
  timer and the two interface FIFOs read over the register port.
  Assumes a host on the same clock that obeys the empty flag and uses
  one-cycle strobes; pins measure_i and test_i are asynchronous.
*/
// Design decisions made here: the address map and the plain strobed port.
`timescale 1ns/1ps
`include "tef_defines.svh"

// Overview of operation
// - register 11 bits 16..26 each unmask one error event.
// - error flag is OR of unmasked hit full, interface full, pll unlock.
// - test-select bit in register 3 swaps three test inputs into measuring path.
// - extra delay setting 0..3 gives 5.5 ns plus 1 ns per step.
// - speed and edge delay settings sit in registers 2, 3 and 4.
// - coarse counter saturates at 32767 periods of 54 fine bins.
// - each interface fifo shows high-active empty; never read it while empty.
// - master reset clears fifos, event status, irq line and counters, keeps configuration.
// - interrupt flag is OR of events unmasked by register 12 bits 13..25.
module tef_top #(
  parameter int DEPTH = `TEF_IFIFO_DEPTH
) (
  input  wire logic                clk_sys_i,
  input  wire logic                srst_i,
  input  wire logic                ce_i,
  input  wire tef_pkg::tef_addr_t  addr_i,
  input  wire tef_pkg::tef_word_t  wr_data_i,
  input  wire logic                wr_i,
  input  wire logic                rd_i,
  output logic [`TEF_DATA_W-1:0]   rd_data_o,
  input  wire logic [2:0]          measure_i,
  input  wire logic [2:0]          test_i,
  input  wire logic [7:0]          hit_fifo_full_i,
  input  wire logic [7:0]          hit_fifo_empty_i,
  input  wire logic                pll_locked_i,
  input  wire logic                result1_valid_i,
  input  wire tef_pkg::tef_result_t result1_data_i,
  input  wire logic                result2_valid_i,
  input  wire tef_pkg::tef_result_t result2_data_i,
  output logic [2:0]               meas_path_o,
  output logic [1:0]               edge_delay_code_o,
  output logic [6:0]               pair_res_tenth_ns_o,
  output logic [14:0]              coarse_count_o,
  output logic                     range_end_o,
  output logic                     error_flag_out_o,
  output logic                     interrupt_flag_out_o,
  output logic                     fifo1_empty_flag_o,
  output logic                     fifo1_empty_flag_oe_n_o,
  output logic                     fifo1_level_reached_o,
  output logic                     fifo2_empty_flag_o,
  output logic                     fifo2_level_reached_o,
  output logic                     irq_o
);
  import tef_pkg::*;

  localparam int CW = $clog2(DEPTH + 1);

  // ***************************************************************
  // declarations
  // ***************************************************************
  tef_word_t        cfg_speed;
  tef_word_t        cfg_test;
  tef_word_t        cfg_ctrl;
  tef_word_t        cfg_fill;
  tef_word_t        cfg_timer;
  tef_word_t        cfg_err_en;
  tef_word_t        cfg_irq_en;
  logic [3:0]       evt_stat;
  logic [3:0]       evt_mask;
  logic [3:0]       evt_set;
  logic [3:0]       evt_clr;
  logic [5:0]       pin_s1;
  logic [5:0]       pin_s2;
  logic [5:0]       pin_s3;
  logic [5:0]       pin_filt;
  logic [5:0]       pin_agree;
  logic [2:0]       sel_path;
  logic             start_prev;
  logic             start_edge;
  logic             mreset;
  logic             wr_ctrl;
  logic             rd_fifo1;
  logic             rd_fifo2;
  logic             bad_read;
  logic [10:0]      err_events;
  logic [12:0]      irq_events;
  logic             err_prev;
  logic             irq_prev;
  logic             lvl_prev;
  logic [1:0]       d_speed;
  logic [1:0]       d_rise;
  logic [1:0]       d_fall;
  logic [1:0]       d_gen;
  logic [1:0]       d_max01;
  logic [1:0]       d_max23;
  logic [1:0]       next_delay;
  logic [5:0]       fine_cnt;
  logic             coarse_run;
  tef_timer_state_t tmr_state;
  logic [12:0]      tmr_cnt;
  logic [12:0]      tmr_period;

  tef_fifo_if #(.W(`TEF_RESULT_W), .CW(CW)) f1 ();
  tef_fifo_if #(.W(`TEF_RESULT_W), .CW(CW)) f2 ();

  // ***************************************************************
  // register port decode
  // ***************************************************************
  assign wr_ctrl  = wr_i && (addr_i == `TEF_REG_CTRL);
  assign mreset   = wr_ctrl && wr_data_i[`TEF_MRESET_BIT];
  assign rd_fifo1 = rd_i && (addr_i == `TEF_REG_FIFO1);
  assign rd_fifo2 = rd_i && (addr_i == `TEF_REG_FIFO2);
  // a read of an empty fifo pops nothing and is reported
  assign bad_read = (rd_fifo1 && f1.empty) || (rd_fifo2 && f2.empty);

  // configuration survives master reset; the command bit is not stored
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      cfg_speed  <= `TEF_CFG_RST;
      cfg_test   <= `TEF_CFG_RST;
      cfg_ctrl   <= `TEF_CFG_RST;
      cfg_fill   <= `TEF_CFG_RST;
      cfg_timer  <= `TEF_CFG_RST;
      cfg_err_en <= `TEF_CFG_RST;
      cfg_irq_en <= `TEF_CFG_RST;
      evt_mask   <= `TEF_STAT_RST;
    end else if (ce_i && wr_i) begin
      unique case (addr_i)
        `TEF_REG_SPEED:    cfg_speed  <= wr_data_i;
        `TEF_REG_TEST:     cfg_test   <= wr_data_i;
        `TEF_REG_CTRL: begin
          cfg_ctrl <= wr_data_i;
          cfg_ctrl[`TEF_MRESET_BIT] <= 1'b0;
        end
        `TEF_REG_FILL:     cfg_fill   <= wr_data_i;
        `TEF_REG_TIMER:    cfg_timer  <= wr_data_i;
        `TEF_REG_ERR_EN:   cfg_err_en <= wr_data_i;
        `TEF_REG_IRQ_EN:   cfg_irq_en <= wr_data_i;
        `TEF_REG_EVT_MASK: evt_mask   <= wr_data_i[3:0];
        default: begin
        end
      endcase
    end
  end

  // read data stand in the cycle after the strobe and only there
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      rd_data_o <= '0;
    end else if (ce_i) begin
      rd_data_o <= '0;
      if (rd_i) begin
        unique case (addr_i)
          `TEF_REG_SPEED:    rd_data_o <= cfg_speed;
          `TEF_REG_TEST:     rd_data_o <= cfg_test;
          `TEF_REG_CTRL:     rd_data_o <= cfg_ctrl;
          `TEF_REG_FILL:     rd_data_o <= cfg_fill;
          `TEF_REG_TIMER:    rd_data_o <= cfg_timer;
          `TEF_REG_ERR_EN:   rd_data_o <= cfg_err_en;
          `TEF_REG_IRQ_EN:   rd_data_o <= cfg_irq_en;
          `TEF_REG_EVT_MASK: rd_data_o <= {24'h000000, evt_mask};
          `TEF_REG_EVT_STAT: rd_data_o <= {24'h000000, evt_stat};
          `TEF_REG_STATE:    rd_data_o <= {11'h000, tmr_state, coarse_count_o};
          `TEF_REG_FIFO1: begin
            if (!f1.empty) begin
              rd_data_o <= {5'h00, f1.head};
            end
          end
          `TEF_REG_FIFO2: begin
            if (!f2.empty) begin
              rd_data_o <= {5'h00, f2.head};
            end
          end
          default:           rd_data_o <= '0;
        endcase
      end
    end
  end

  // ***************************************************************
  // pin synchronisers and test-input multiplexer
  // ***************************************************************
  // a bit only moves once the second and third stages agree
  assign pin_agree = ~(pin_s2 ^ pin_s3);

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      pin_s1   <= '0;
      pin_s2   <= '0;
      pin_s3   <= '0;
      pin_filt <= '0;
    end else if (ce_i) begin
      pin_s1   <= {test_i, measure_i};
      pin_s2   <= pin_s1;
      pin_s3   <= pin_s2;
      pin_filt <= (pin_s2 & pin_agree) | (pin_filt & ~pin_agree);
    end
  end

  // test inputs take the place of the measure inputs, same behaviour
  assign sel_path = cfg_test[`TEF_GTEST_BIT] ? pin_filt[5:3] : pin_filt[2:0];

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      meas_path_o <= '0;
      start_prev  <= 1'b0;
    end else if (ce_i) begin
      meas_path_o <= sel_path;
      start_prev  <= sel_path[0];
    end
  end

  assign start_edge = sel_path[0] & ~start_prev;

  // ***************************************************************
  // extra processing delay
  // ***************************************************************
  // the largest of the four settings governs; the edge path is only as
  // fast as its slowest stage
  assign d_speed    = cfg_speed[`TEF_SPEED_LO +: 2];
  assign d_rise     = cfg_test[`TEF_RISE_LO +: 2];
  assign d_fall     = cfg_test[`TEF_FALL_LO +: 2];
  assign d_gen      = cfg_ctrl[`TEF_GEN_LO +: 2];
  assign d_max01    = (d_speed > d_rise) ? d_speed : d_rise;
  assign d_max23    = (d_fall > d_gen) ? d_fall : d_gen;
  assign next_delay = (d_max01 > d_max23) ? d_max01 : d_max23;

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      edge_delay_code_o   <= '0;
      pair_res_tenth_ns_o <= `TEF_PPR_BASE;
    end else if (ce_i) begin
      edge_delay_code_o   <= next_delay;
      pair_res_tenth_ns_o <= 7'(`TEF_PPR_BASE + `TEF_PPR_STEP * next_delay);
    end
  end

  // ***************************************************************
  // coarse range counter
  // ***************************************************************
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      fine_cnt       <= '0;
      coarse_count_o <= '0;
      coarse_run     <= 1'b0;
      range_end_o    <= 1'b0;
    end else if (ce_i) begin
      if (mreset) begin
        fine_cnt       <= '0;
        coarse_count_o <= '0;
        coarse_run     <= 1'b0;
        range_end_o    <= 1'b0;
      end else if (start_edge) begin
        fine_cnt       <= '0;
        coarse_count_o <= '0;
        coarse_run     <= 1'b1;
        range_end_o    <= 1'b0;
      end else if (coarse_run) begin
        if (fine_cnt == 6'(`TEF_FINE_BINS - 1'b1)) begin
          fine_cnt <= '0;
          if (coarse_count_o == `TEF_COARSE_FULL - 15'h0001) begin
            coarse_count_o <= `TEF_COARSE_FULL;
            coarse_run     <= 1'b0;
            range_end_o    <= 1'b1;
          end else begin
            coarse_count_o <= 15'(coarse_count_o + 1'b1);
          end
        end else begin
          fine_cnt <= 6'(fine_cnt + 1'b1);
        end
      end
    end
  end

  // ***************************************************************
  // measurement timer
  // ***************************************************************
  assign tmr_period = cfg_timer[`TEF_TMR_HI:`TEF_TMR_LO];

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      tmr_state <= tmr_idle;
      tmr_cnt   <= '0;
    end else if (ce_i) begin
      if (mreset) begin
        tmr_state <= tmr_idle;
        tmr_cnt   <= '0;
      end else begin
        unique case (tmr_state)
          tmr_idle: begin
            if (start_edge && cfg_ctrl[`TEF_TMR_ON_START]) begin
              tmr_cnt   <= tmr_period;
              tmr_state <= (tmr_period == '0) ? tmr_done : tmr_run;
            end
          end
          tmr_run: begin
            if (tmr_cnt == 13'h0001) begin
              tmr_state <= tmr_done;
            end
            tmr_cnt <= 13'(tmr_cnt - 1'b1);
          end
          tmr_done: begin
            tmr_cnt <= '0;
          end
        endcase
      end
    end
  end

  // ***************************************************************
  // interface fifos
  // ***************************************************************
  assign f1.push      = result1_valid_i;
  assign f1.push_data = result1_data_i;
  assign f1.pop       = ce_i & rd_fifo1;
  assign f1.clear     = mreset;
  assign f1.fill      = CW'(cfg_fill[`TEF_FILL_HI:`TEF_FILL_LO]);
  assign f2.push      = result2_valid_i;
  assign f2.push_data = result2_data_i;
  assign f2.pop       = ce_i & rd_fifo2;
  assign f2.clear     = mreset;
  assign f2.fill      = CW'(cfg_fill[`TEF_FILL_HI:`TEF_FILL_LO]);

  tef_fifo #(.W(`TEF_RESULT_W), .DEPTH(DEPTH), .CW(CW)) u_fifo1 (
    .clk_sys_i (clk_sys_i),
    .srst_i    (srst_i),
    .ce_i      (ce_i),
    .f         (f1.store)
  );

  tef_fifo #(.W(`TEF_RESULT_W), .DEPTH(DEPTH), .CW(CW)) u_fifo2 (
    .clk_sys_i (clk_sys_i),
    .srst_i    (srst_i),
    .ce_i      (ce_i),
    .f         (f2.store)
  );

  // ***************************************************************
  // error and interrupt flags
  // ***************************************************************
  assign err_events = {~pll_locked_i, f2.full, f1.full, hit_fifo_full_i};
  assign irq_events = {tmr_state == tmr_done, &hit_fifo_empty_i,
                       ~pll_locked_i, f2.full, f1.full, hit_fifo_full_i};

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      error_flag_out_o     <= 1'b0;
      interrupt_flag_out_o <= 1'b0;
    end else if (ce_i) begin
      // level, refreshed every cycle while the cause lasts
      error_flag_out_o <= |(err_events & cfg_err_en[`TEF_ERR_EN_HI:`TEF_ERR_EN_LO]);
      interrupt_flag_out_o <= |(irq_events & cfg_irq_en[`TEF_IRQ_EN_HI:`TEF_IRQ_EN_LO]);
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      fifo1_empty_flag_o      <= 1'b1;
      fifo1_empty_flag_oe_n_o <= 1'b1;
      fifo1_level_reached_o   <= 1'b0;
      fifo2_empty_flag_o      <= 1'b1;
      fifo2_level_reached_o   <= 1'b0;
    end else if (ce_i) begin
      fifo1_empty_flag_o      <= f1.empty;
      fifo1_empty_flag_oe_n_o <= ~cfg_ctrl[`TEF_EFLAG_DRV_BIT];
      fifo1_level_reached_o   <= f1.level_hit;
      fifo2_empty_flag_o      <= f2.empty;
      fifo2_level_reached_o   <= f2.level_hit;
    end
  end

  // ***************************************************************
  // event status, mask and interrupt line
  // ***************************************************************
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      err_prev <= 1'b0;
      irq_prev <= 1'b0;
      lvl_prev <= 1'b0;
    end else if (ce_i) begin
      err_prev <= error_flag_out_o;
      irq_prev <= interrupt_flag_out_o;
      lvl_prev <= fifo1_level_reached_o;
    end
  end

  always_comb begin
    evt_set = '0;
    evt_set[`TEF_EVT_ERR]     = error_flag_out_o & ~err_prev;
    evt_set[`TEF_EVT_INT]     = interrupt_flag_out_o & ~irq_prev;
    evt_set[`TEF_EVT_LEVEL]   = fifo1_level_reached_o & ~lvl_prev;
    evt_set[`TEF_EVT_BADREAD] = bad_read;
  end

  assign evt_clr = (wr_i && addr_i == `TEF_REG_EVT_STAT) ? wr_data_i[3:0] : 4'h0;

  // set wins over a simultaneous write-one-to-clear
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      evt_stat <= `TEF_STAT_RST;
      irq_o    <= 1'b0;
    end else if (ce_i) begin
      if (mreset) begin
        evt_stat <= `TEF_STAT_RST;
        irq_o    <= 1'b0;
      end else begin
        evt_stat <= (evt_stat & ~evt_clr) | evt_set;
        irq_o    <= |(((evt_stat & ~evt_clr) | evt_set) & evt_mask);
      end
    end
  end

endmodule : tef_top

/* rtl/tef_defines.svh */
/*
  Register offsets, field positions, reset values and timing figures of the
  error-flag and measurement-flow slice. Definitions only; included by the
  package and every design file that needs a number.
*/
`ifndef TEF_DEFINES_SVH
`define TEF_DEFINES_SVH

// ***************************************************************
// bus geometry
// ***************************************************************
`define TEF_ADDR_W        4
`define TEF_DATA_W        28
`define TEF_RESULT_W      23

// ***************************************************************
// register offsets (register index on the plain port)
// ***************************************************************
`define TEF_REG_SPEED     4'h2
`define TEF_REG_TEST      4'h3
`define TEF_REG_CTRL      4'h4
`define TEF_REG_FILL      4'h6
`define TEF_REG_TIMER     4'h7
`define TEF_REG_FIFO1     4'h8
`define TEF_REG_FIFO2     4'h9
`define TEF_REG_EVT_STAT  4'ha
`define TEF_REG_ERR_EN    4'hb
`define TEF_REG_IRQ_EN    4'hc
`define TEF_REG_EVT_MASK  4'hd
`define TEF_REG_STATE     4'hf

// ***************************************************************
// field positions
// ***************************************************************
`define TEF_ERR_EN_LO     16
`define TEF_ERR_EN_HI     26
`define TEF_IRQ_EN_LO     13
`define TEF_IRQ_EN_HI     25
`define TEF_GTEST_BIT     24
`define TEF_SPEED_LO      26
`define TEF_RISE_LO       0
`define TEF_FALL_LO       2
`define TEF_GEN_LO        0
`define TEF_TMR_ON_START  8
`define TEF_MRESET_BIT    22
`define TEF_EFLAG_DRV_BIT 25
`define TEF_QUIET_BIT     26
`define TEF_TMR_LO        15
`define TEF_TMR_HI        27
`define TEF_FILL_LO       0
`define TEF_FILL_HI       7

// ***************************************************************
// reset values and figures
// ***************************************************************
`define TEF_CFG_RST       28'h0000000
`define TEF_STAT_RST      4'h0
`define TEF_IFIFO_DEPTH   256
`define TEF_PPR_BASE      7'h37
`define TEF_PPR_STEP      7'h0a
`define TEF_COARSE_FULL   15'h7fff
`define TEF_FINE_BINS     6'h36
`define TEF_EVT_ERR       0
`define TEF_EVT_INT       1
`define TEF_EVT_LEVEL     2
`define TEF_EVT_BADREAD   3

`endif

/* rtl/tef_pkg.sv */
/*
  Types shared by the slice. Assumes tef_defines.svh is on the include path.
*/
`include "tef_defines.svh"

package tef_pkg;

  typedef logic [`TEF_ADDR_W-1:0]   tef_addr_t;
  typedef logic [`TEF_DATA_W-1:0]   tef_word_t;
  typedef logic [`TEF_RESULT_W-1:0] tef_result_t;

  typedef enum logic [1:0] {
    tmr_idle,
    tmr_run,
    tmr_done
  } tef_timer_state_t;

endpackage : tef_pkg

/* rtl/tef_fifo_if.sv */
/*
  Carrier between the top of the slice and one interface FIFO.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps

interface tef_fifo_if #(
  parameter int W  = 23,
  parameter int CW = 9
);
  logic          push;
  logic [W-1:0]  push_data;
  logic          pop;
  logic          clear;
  logic [CW-1:0] fill;
  logic [W-1:0]  head;
  logic          empty;
  logic          full;
  logic          level_hit;

  modport store (input push, push_data, pop, clear, fill,
                 output head, empty, full, level_hit);
  modport user  (output push, push_data, pop, clear, fill,
                 input head, empty, full, level_hit);
endinterface : tef_fifo_if

/* rtl/tef_fifo.sv */
/*
  One interface FIFO: flip-flop storage, active-high empty, full and
  load-level flags. Assumes the user never pops while empty; such a pop
  is ignored anyway.
*/
`timescale 1ns/1ps

module tef_fifo #(
  parameter int W     = 23,
  parameter int DEPTH = 256,
  parameter int CW    = 9
) (
  input  wire logic clk_sys_i,
  input  wire logic srst_i,
  input  wire logic ce_i,
  tef_fifo_if.store f
);
  import tef_pkg::*;

  localparam int PW = $clog2(DEPTH);

  logic [W-1:0]  mem [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [CW-1:0] count;
  logic          do_push;
  logic          do_pop;

  // ***************************************************************
  // flags
  // ***************************************************************
  assign f.empty     = (count == '0);
  assign f.full      = (count == CW'(DEPTH));
  assign f.level_hit = (count >= f.fill);
  assign f.head      = mem[rd_ptr];

  // a push into a full fifo is lost; the full event reports it
  assign do_push = f.push & ~f.full;
  assign do_pop  = f.pop & ~f.empty;

  // ***************************************************************
  // storage
  // ***************************************************************
  always_ff @(posedge clk_sys_i) begin
    if (ce_i && do_push) begin
      mem[wr_ptr] <= f.push_data;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else if (ce_i) begin
      if (f.clear) begin
        wr_ptr <= '0;
        rd_ptr <= '0;
        count  <= '0;
      end else begin
        if (do_push) begin
          wr_ptr <= PW'(wr_ptr + 1'b1);
        end
        if (do_pop) begin
          rd_ptr <= PW'(rd_ptr + 1'b1);
        end
        if (do_push && !do_pop) begin
          count <= CW'(count + 1'b1);
        end else if (do_pop && !do_push) begin
          count <= CW'(count - 1'b1);
        end
      end
    end
  end

endmodule : tef_fifo

/* testbench/tef_checker.sv */
/* port checker of tef_top, bound below.
   assumes srst_i synchronous high, ce_i high. */
`timescale 1ns/1ps
`include "tef_defines.svh"
module tef_checker (
  input wire logic        clk_sys_i,
  input wire logic        srst_i,
  input wire logic        ce_i,
  input wire logic [3:0]  addr_i,
  input wire logic [27:0] wr_data_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [27:0] rd_data_o,
  input wire logic [7:0]  hit_fifo_full_i,
  input wire logic        pll_locked_i,
  input wire logic        result1_valid_i,
  input wire logic        error_flag_out_o,
  input wire logic        irq_o,
  input wire logic        fifo1_empty_flag_o,
  input wire logic [1:0]  edge_delay_code_o,
  input wire logic [6:0]  pair_res_tenth_ns_o
);
  // ****
  // assertions
  // ****
  logic [10:0] err_en;
  logic        mrst;
  assign mrst = ce_i && wr_i && addr_i == `TEF_REG_CTRL && wr_data_i[`TEF_MRESET_BIT];
  // error enables survive master reset
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) err_en <= 11'h0;
    else if (ce_i && wr_i && addr_i == `TEF_REG_ERR_EN) err_en <= wr_data_i[26:16];
  end
  default clocking dc @(posedge clk_sys_i);
  endclocking
  default disable iff (srst_i);
  a_err_set: assert property (ce_i && !mrst && ((|(err_en[7:0] & hit_fifo_full_i)) ||
    (err_en[10] && !pll_locked_i)) |=> error_flag_out_o) else $error("error flag missing");
  a_err_off: assert property (ce_i && err_en == 11'h0 |=> !error_flag_out_o)
    else $error("error flag without enable");
  a_mrst_irq: assert property (mrst |=> !irq_o) else $error("irq kept over master reset");
  a_mrst_fifo: assert property (mrst && !result1_valid_i ##1 !result1_valid_i |=> fifo1_empty_flag_o)
    else $error("fifo kept over master reset");
  a_push_seen: assert property (ce_i && result1_valid_i && !mrst ##1 (!wr_i && !rd_i)[*3]
    |-> !fifo1_empty_flag_o) else $error("empty flag after push");
  a_empty_read: assert property (rd_i && addr_i == `TEF_REG_FIFO1 && fifo1_empty_flag_o &&
    !$past(result1_valid_i) |=> rd_data_o == 28'h0) else $error("empty read data");
  a_rdata_cause: assert property (rd_data_o != 28'h0 |-> $past(rd_i)) else $error("read data without read");
  a_res_table: assert property (pair_res_tenth_ns_o == 7'h37 + 7'h0a * {5'h0, edge_delay_code_o})
    else $error("pair resolution off");
endmodule : tef_checker
bind tef_top tef_checker chk_u (.*);

/* testbench/tef_host_model.sv */
/* host model: register port master tasks.
   assumes read data one cycle after the strobe. */
`timescale 1ns/1ps
`include "tef_defines.svh"
module tef_host_model (
  input  wire logic [27:0]  rd_data_i,
  input  wire logic         clk_sys_i,
  input  wire logic         empty_i,
  output tef_pkg::tef_addr_t addr_o,
  output tef_pkg::tef_word_t wr_data_o,
  output logic              wr_o,
  output logic              rd_o
);
  import tef_pkg::*;
  // ****
  // bus tasks
  // ****
  initial {addr_o, wr_data_o, wr_o, rd_o} = '0;
  task automatic wr_reg(input tef_addr_t a, input tef_word_t d);
    @(posedge clk_sys_i);
    addr_o    <= a;
    wr_data_o <= d;
    wr_o      <= 1'b1;
    @(posedge clk_sys_i);
    wr_o      <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input tef_addr_t a, output tef_word_t d);
    @(posedge clk_sys_i);
    addr_o <= a;
    rd_o   <= 1'b1;
    @(posedge clk_sys_i);
    rd_o <= 1'b0;
    @(posedge clk_sys_i);
    d = rd_data_i;
  endtask : rd_reg
  // the flag lags a pop by one edge, so wait before looking again
  task automatic drain(output int n);
    tef_word_t d;
    n = 0;
    while (empty_i === 1'b0 && n < 16) begin
      rd_reg(`TEF_REG_FIFO1, d);
      repeat (2) @(posedge clk_sys_i);
      n++;
    end
  endtask : drain
endmodule : tef_host_model

/* testbench/tef_top_tb.sv */
/* bench of tef_top with host model and bound checker.
   assumes ce_i high, fifo2 and hit-empty inputs idle. */
`timescale 1ns/1ps
`include "tef_defines.svh"
module tef_top_tb;
  import tef_pkg::*;
  logic        clk_sys_i, srst_i, wr_i, rd_i, pll, vld, e1, l1, err_f, int_f, irq;
  logic [2:0]  meas, tst, path;
  logic [7:0]  hit;
  logic [1:0]  code;
  logic [6:0]  pres;
  logic [27:0] rd_data;
  tef_addr_t   addr;
  tef_word_t   wdata, d;
  tef_result_t r1;
  int          failures, cmp_count, n;
  tef_top #(.DEPTH(8)) dut_u (.clk_sys_i, .srst_i, .ce_i(1'b1), .addr_i(addr),
    .wr_data_i(wdata), .wr_i, .rd_i, .rd_data_o(rd_data), .measure_i(meas), .test_i(tst),
    .hit_fifo_full_i(hit), .hit_fifo_empty_i(8'h00), .pll_locked_i(pll), .result1_valid_i(vld),
    .result1_data_i(r1), .result2_valid_i(1'b0), .result2_data_i(23'h0), .meas_path_o(path),
    .edge_delay_code_o(code), .pair_res_tenth_ns_o(pres), .coarse_count_o(), .range_end_o(),
    .error_flag_out_o(err_f), .interrupt_flag_out_o(int_f), .fifo1_empty_flag_o(e1),
    .fifo1_empty_flag_oe_n_o(), .fifo1_level_reached_o(l1), .fifo2_empty_flag_o(),
    .fifo2_level_reached_o(), .irq_o(irq));
  tef_host_model host_u (.rd_data_i(rd_data), .clk_sys_i, .empty_i(e1), .addr_o(addr),
    .wr_data_o(wdata), .wr_o(wr_i), .rd_o(rd_i));
  // ****
  // tasks and sequence
  // ****
  task automatic chk(input string nm, input logic [27:0] seen, input logic [27:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic end_sim;
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim
  task automatic tk(input int k);
    repeat (k) @(posedge clk_sys_i);
  endtask : tk
  task automatic push(input int k);
    for (int i = 0; i < k; i++) begin
      @(posedge clk_sys_i);
      vld <= 1'b1;
      r1  <= 23'h400 + 23'(i);
    end
    @(posedge clk_sys_i);
    vld <= 1'b0;
  endtask : push
  initial begin
    clk_sys_i = 1'b0;
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end
  initial begin
    {vld, r1, hit, meas, tst, failures, cmp_count} = '0;
    pll    = 1'b1;
    srst_i = 1'b1;
    tk(6);
    srst_i <= 1'b0;
    for (int c = 0; c < 4; c++) begin
      host_u.wr_reg(`TEF_REG_SPEED, tef_word_t'(c) << 26);
      tk(3);
      chk("pair_res", 28'(pres), 28'(7'h37 + 7'h0a * 7'(c)));
    end
    host_u.wr_reg(`TEF_REG_SPEED, 28'h0);
    tst <= 3'h6;
    host_u.wr_reg(`TEF_REG_TEST, 28'h1000002);
    tk(4);
    chk("rise_code", 28'(code), 28'h2);
    chk("test_path", 28'(path), 28'h6);
    host_u.wr_reg(`TEF_REG_TEST, 28'h2);
    host_u.wr_reg(`TEF_REG_ERR_EN, 28'h7ff0000);
    hit <= 8'h80;
    tk(3);
    chk("err_hit", 28'(err_f), 28'h1);
    hit <= 8'h00;
    pll <= 1'b0;
    tk(3);
    chk("err_pll", 28'(err_f), 28'h1);
    pll <= 1'b1;
    host_u.wr_reg(`TEF_REG_ERR_EN, 28'h0010000);
    hit <= 8'h02;
    tk(3);
    chk("err_masked", 28'(err_f), 28'h0);
    hit <= 8'h00;
    host_u.wr_reg(`TEF_REG_ERR_EN, 28'h7ff0000);
    host_u.wr_reg(`TEF_REG_FILL, 28'h3);
    push(3);
    tk(3);
    chk("level", 28'(l1), 28'h1);
    for (int i = 0; i < 3; i++) begin
      host_u.rd_reg(`TEF_REG_FIFO1, d);
      chk("word", d & 28'h7fffff, 28'h400 + 28'(i));
    end
    tk(2);
    chk("empty", 28'(e1), 28'h1);
    host_u.rd_reg(`TEF_REG_FIFO1, d);
    chk("empty_read", d, 28'h0);
    host_u.rd_reg(`TEF_REG_EVT_STAT, d);
    chk("bad_read_evt", d & 28'h8, 28'h8);
    host_u.rd_reg(4'h5, d);
    chk("unmapped", d, 28'h0);
    host_u.wr_reg(`TEF_REG_IRQ_EN, 28'h2000000);
    host_u.wr_reg(`TEF_REG_TIMER, 28'h0141fb4);
    host_u.wr_reg(`TEF_REG_CTRL, 28'h6000100);
    host_u.wr_reg(`TEF_REG_EVT_MASK, 28'h2);
    host_u.wr_reg(`TEF_REG_CTRL, 28'h6400100);
    meas <= 3'h1;
    for (n = 0; int_f !== 1'b1; n++) begin
      @(posedge clk_sys_i);
      if (n > 200) begin
        failures++;
        end_sim();
      end
    end
    chk("timer_len", 28'(n >= 40), 28'h1);
    tk(3);
    chk("irq_set", 28'(irq), 28'h1);
    host_u.wr_reg(`TEF_REG_EVT_STAT, 28'h2);
    tk(2);
    chk("irq_clr", 28'(irq), 28'h0);
    push(2);
    tk(4);
    host_u.drain(n);
    chk("drained", 28'(n), 28'h2);
    host_u.rd_reg(`TEF_REG_CTRL, d);
    chk("ctrl_kept", d, 28'h6000100);
    push(1);
    host_u.wr_reg(`TEF_REG_CTRL, 28'h6400100);
    tk(3);
    chk("mrst_empty", 28'(e1), 28'h1);
    host_u.rd_reg(`TEF_REG_ERR_EN, d);
    chk("err_en_kept", d, 28'h7ff0000);
    end_sim();
  end
endmodule : tef_top_tb
